// file: src/cspu_top.sv
`timescale 1ns/100ps
// =====================================================================
// What this block does
// - Send the frame every programmed period; period zero sends nothing.
// - Accept the receive message only while its timeout is non-zero.
// - Optional filter restricts reception to one sender address, off at reset.
// - Expected sender address is eight bits, reset to the null address.
// - Each transmit field starts at a chosen byte 0-7 and bit 0-7.
// - Each transmit field has a selectable size, two bytes by default.
// - Transmit values scaled by per-signal resolution and offset, defaults 0.001, 0.
// - Received field is taken from a chosen byte 0-7 and bit 0-7.
// - Decoded value against off 0.0 and on 2.0 thresholds gives on/off.
module cspu_top #(
  parameter int MS_CYCLES = cspu_pkg::MS_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] sig_val_0,
  input  wire logic [31:0] sig_val_1,
  input  wire logic [31:0] sig_val_2,
  input  wire logic [31:0] sig_val_3,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [28:0] tx_id,
  output logic      [63:0] tx_data,
  input  wire logic        rx_valid,
  input  wire logic [28:0] rx_id,
  input  wire logic [63:0] rx_data,
  output logic             rx_on,
  output logic             rx_lost,
  output logic             irq
);
  localparam int CW = cspu_pkg::CFG_W;
  localparam int IW = cspu_pkg::IRQ_W;

  // =====================================================================
  // Helpers
  function automatic logic [63:0] field_mask(input logic [CW-1:0] cfg);
    unique case (cfg[cspu_pkg::F_SIZE +: 2])
      2'h0:    field_mask = 64'h00000000000000ff;
      2'h1:    field_mask = 64'h000000000000ffff;
      default: field_mask = 64'h00000000ffffffff;
    endcase
  endfunction

  function automatic logic [5:0] field_pos(input logic [CW-1:0] cfg);
    field_pos = {cfg[cspu_pkg::F_BYTE +: 3], cfg[cspu_pkg::F_BIT +: 3]};
  endfunction

  function automatic logic [63:0] place(input logic [63:0]   d,
                                        input logic [31:0]   raw,
                                        input logic [CW-1:0] cfg);
    logic [63:0] m;
    m     = field_mask(cfg);
    place = (d & ~(m << field_pos(cfg))) | (({32'h0, raw} & m) << field_pos(cfg));
  endfunction

  function automatic logic [31:0] extract(input logic [63:0] d, input logic [CW-1:0] cfg);
    logic [63:0] t;
    t       = (d >> field_pos(cfg)) & field_mask(cfg);
    extract = t[31:0];
  endfunction

  // =====================================================================
  // Registers
  logic [7:0]    sa_own_reg;
  logic          filt_en_reg;
  logic [17:0]   tx_pgn_reg;
  logic [2:0]    prio_reg;
  logic [15:0]   tx_per_reg;
  logic [7:0]    tx_dest_reg;
  logic [CW-1:0] sig_cfg_reg [4];
  logic [31:0]   sig_scl_reg [4];
  logic [31:0]   sig_off_reg [4];
  logic [17:0]   rx_pgn_reg;
  logic [15:0]   rx_tmo_reg;
  logic [7:0]    rx_sa_reg;
  logic [CW-1:0] rx_cfg_reg;
  logic [31:0]   rx_res_reg;
  logic [31:0]   rx_off_reg;
  logic [31:0]   th_off_reg;
  logic [31:0]   th_on_reg;
  logic [31:0]   rx_value_reg;
  logic [IW-1:0] irq_stat_reg;
  logic [IW-1:0] irq_mask_reg;
  logic [IW-1:0] irq_set;
  logic [7:0]    dp_addr_reg;
  logic          dp_wr_reg;
  logic          dp_act_reg;
  logic          wr_go;
  logic [31:0]   rd_next;
  logic [31:0]   sig_raw [4];
  logic [31:0]   sig_val [4];
  logic          ms_tick;

  assign sig_val[0] = sig_val_0;
  assign sig_val[1] = sig_val_1;
  assign sig_val[2] = sig_val_2;
  assign sig_val[3] = sig_val_3;

  // =====================================================================
  // AHB-Lite slave: one wait state, always OKAY
  assign wr_go = ce && dp_act_reg && dp_wr_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dp_act_reg  <= 1'b0;
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 8'h0;
      hreadyout   <= 1'b1;
      hrdata      <= 32'h0;
      hresp       <= 1'b0;
    end else if (ce) begin
      if (dp_act_reg) begin
        dp_act_reg <= 1'b0;
        hreadyout  <= 1'b1;
        hrdata     <= dp_wr_reg ? 32'h0 : rd_next;
      end else if (hsel && hready && htrans[1]) begin
        dp_act_reg  <= 1'b1;
        dp_wr_reg   <= hwrite;
        dp_addr_reg <= haddr[7:0];
        hreadyout   <= 1'b0;
      end
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    rd_next = 32'h0;
    if (dp_addr_reg[7:4] >= cspu_pkg::A_SIG_LO && dp_addr_reg[7:4] <= cspu_pkg::A_SIG_HI) begin
      unique case (dp_addr_reg[3:2])
        cspu_pkg::A_SIG_CFG: rd_next = 32'(sig_cfg_reg[2'(dp_addr_reg[7:4] - 4'h1)]);
        cspu_pkg::A_SIG_SCL: rd_next = sig_scl_reg[2'(dp_addr_reg[7:4] - 4'h1)];
        cspu_pkg::A_SIG_OFF: rd_next = sig_off_reg[2'(dp_addr_reg[7:4] - 4'h1)];
        default:             rd_next = 32'h0;
      endcase
    end else begin
      unique case (dp_addr_reg)
        cspu_pkg::A_CTRL:     rd_next = {23'h0, filt_en_reg, sa_own_reg};
        cspu_pkg::A_TX_PGN:   rd_next = {5'h0, prio_reg, 6'h0, tx_pgn_reg};
        cspu_pkg::A_TX_PER:   rd_next = {16'h0, tx_per_reg};
        cspu_pkg::A_TX_DEST:  rd_next = {24'h0, tx_dest_reg};
        cspu_pkg::A_RX_PGN:   rd_next = {14'h0, rx_pgn_reg};
        cspu_pkg::A_RX_TMO:   rd_next = {16'h0, rx_tmo_reg};
        cspu_pkg::A_RX_SA:    rd_next = {24'h0, rx_sa_reg};
        cspu_pkg::A_RX_CFG:   rd_next = 32'(rx_cfg_reg);
        cspu_pkg::A_RX_RES:   rd_next = rx_res_reg;
        cspu_pkg::A_RX_OFF:   rd_next = rx_off_reg;
        cspu_pkg::A_RX_THOFF: rd_next = th_off_reg;
        cspu_pkg::A_RX_THON:  rd_next = th_on_reg;
        cspu_pkg::A_RX_VAL:   rd_next = rx_value_reg;
        cspu_pkg::A_STATUS:   rd_next = {30'h0, rx_lost, rx_on};
        cspu_pkg::A_IRQ_STAT: rd_next = 32'(irq_stat_reg);
        cspu_pkg::A_IRQ_MASK: rd_next = 32'(irq_mask_reg);
        default:              rd_next = 32'h0;
      endcase
    end
  end

  // Transmit configuration writes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sa_own_reg  <= cspu_pkg::SA_OWN_DEF;
      filt_en_reg <= 1'b0;
      tx_pgn_reg  <= cspu_pkg::TX_PGN_DEF;
      prio_reg    <= cspu_pkg::PRIO_DEF;
      tx_per_reg  <= 16'h0;
      tx_dest_reg <= cspu_pkg::DEST_DEF;
      for (int i = 0; i < 4; i++) begin
        sig_cfg_reg[i] <= (i == 0) ? cspu_pkg::CFG_SIG0 : cspu_pkg::CFG_SIGN;
        sig_scl_reg[i] <= cspu_pkg::SCL_DEF;
        sig_off_reg[i] <= 32'h0;
      end
    end else if (wr_go) begin
      unique case (dp_addr_reg)
        cspu_pkg::A_CTRL: begin
          sa_own_reg  <= hwdata[7:0];
          filt_en_reg <= hwdata[cspu_pkg::C_FILT];
        end
        cspu_pkg::A_TX_PGN: begin
          tx_pgn_reg <= hwdata[17:0];
          prio_reg   <= hwdata[26:24];
        end
        cspu_pkg::A_TX_PER:  tx_per_reg  <= hwdata[15:0];
        cspu_pkg::A_TX_DEST: tx_dest_reg <= hwdata[7:0];
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (dp_addr_reg[7:4] == 4'(i + 1)) begin
              unique case (dp_addr_reg[3:2])
                cspu_pkg::A_SIG_CFG: sig_cfg_reg[i] <= hwdata[CW-1:0];
                cspu_pkg::A_SIG_SCL: sig_scl_reg[i] <= hwdata;
                cspu_pkg::A_SIG_OFF: sig_off_reg[i] <= hwdata;
                default:             sig_cfg_reg[i] <= sig_cfg_reg[i];
              endcase
            end
          end
        end
      endcase
    end
  end

  // Receive configuration writes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_pgn_reg   <= cspu_pkg::RX_PGN_DEF;
      rx_tmo_reg   <= 16'h0;
      rx_sa_reg    <= cspu_pkg::SA_NULL;
      rx_cfg_reg   <= cspu_pkg::CFG_RX_DEF;
      rx_res_reg   <= cspu_pkg::RES_DEF;
      rx_off_reg   <= 32'h0;
      th_off_reg   <= 32'h0;
      th_on_reg    <= cspu_pkg::THON_DEF;
      irq_mask_reg <= '0;
    end else if (wr_go) begin
      unique case (dp_addr_reg)
        cspu_pkg::A_RX_PGN:   rx_pgn_reg   <= hwdata[17:0];
        cspu_pkg::A_RX_TMO:   rx_tmo_reg   <= hwdata[15:0];
        cspu_pkg::A_RX_SA:    rx_sa_reg    <= hwdata[7:0];
        cspu_pkg::A_RX_CFG:   rx_cfg_reg   <= hwdata[CW-1:0];
        cspu_pkg::A_RX_RES:   rx_res_reg   <= hwdata;
        cspu_pkg::A_RX_OFF:   rx_off_reg   <= hwdata;
        cspu_pkg::A_RX_THOFF: th_off_reg   <= hwdata;
        cspu_pkg::A_RX_THON:  th_on_reg    <= hwdata;
        cspu_pkg::A_IRQ_MASK: irq_mask_reg <= hwdata[IW-1:0];
        default:              rx_pgn_reg   <= rx_pgn_reg;
      endcase
    end
  end

  // =====================================================================
  // Transmit path
  cspu_ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .tick    (ms_tick)
  );

  for (genvar g = 0; g < 4; g++) begin : g_scale
    cspu_tx_scale u_scale (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .ce      (ce),
      .value   (sig_val[g]),
      .offset  (sig_off_reg[g]),
      .scale   (sig_scl_reg[g]),
      .raw     (sig_raw[g])
    );
  end

  logic [15:0] tx_cnt_reg;
  logic        tx_due_reg;
  logic [63:0] pay_next;
  logic [28:0] id_next;

  // Period counter; a due frame waits while the previous one is unsent
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_cnt_reg <= 16'h0;
      tx_due_reg <= 1'b0;
    end else if (ce) begin
      if (tx_per_reg == 16'h0) begin
        tx_cnt_reg <= 16'h0;
        tx_due_reg <= 1'b0;
      end else begin
        if (ms_tick) begin
          if (tx_cnt_reg + 16'h1 >= tx_per_reg) begin
            tx_cnt_reg <= 16'h0;
            tx_due_reg <= 1'b1;
          end else begin
            tx_cnt_reg <= tx_cnt_reg + 16'h1;
          end
        end else if (tx_due_reg && !tx_valid) begin
          tx_due_reg <= 1'b0;
        end
      end
    end
  end

  // Unused payload bits stay all ones; later signals overwrite earlier
  always_comb begin
    pay_next = 64'hffffffffffffffff;
    for (int i = 0; i < 4; i++) begin
      if (sig_cfg_reg[i][cspu_pkg::F_EN]) begin
        pay_next = place(pay_next, sig_raw[i], sig_cfg_reg[i]);
      end
    end
    id_next = {prio_reg, tx_pgn_reg, sa_own_reg};
    if (tx_pgn_reg[15:8] < cspu_pkg::PF_PDU2) begin
      id_next[15:8] = tx_dest_reg;
    end
  end

  // Frame output held until the controller takes it
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_valid <= 1'b0;
      tx_id    <= 29'h0;
      tx_data  <= 64'h0;
    end else if (ce) begin
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end else if (tx_due_reg && !tx_valid && !ms_tick && tx_per_reg != 16'h0) begin
        tx_valid <= 1'b1;
        tx_id    <= id_next;
        tx_data  <= pay_next;
      end
    end
  end

  // =====================================================================
  // Receive path
  logic        rx_en;
  logic        rx_hit;
  logic        rx_pend_reg;
  logic        rx_vld_reg;
  logic [31:0] rx_raw_reg;
  logic [15:0] rx_cnt_reg;
  logic        lost_set;
  logic [63:0] rx_prod;

  assign rx_en  = rx_tmo_reg != 16'h0;
  assign rx_hit = ce && rx_valid && rx_en && rx_id[25:16] == rx_pgn_reg[17:8]
                  && (rx_pgn_reg[15:8] < cspu_pkg::PF_PDU2 || rx_id[15:8] == rx_pgn_reg[7:0])
                  && (!filt_en_reg || rx_id[7:0] == rx_sa_reg);
  assign rx_prod = 64'($signed(rx_raw_reg) * $signed(rx_res_reg));

  // Three stages: extract, scale, compare; one new frame per cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_pend_reg  <= 1'b0;
      rx_vld_reg   <= 1'b0;
      rx_raw_reg   <= 32'h0;
      rx_value_reg <= 32'h0;
      rx_on        <= 1'b0;
    end else if (ce) begin
      rx_pend_reg <= rx_hit;
      rx_vld_reg  <= rx_pend_reg;
      if (rx_hit) begin
        rx_raw_reg <= extract(rx_data, rx_cfg_reg);
      end
      if (rx_pend_reg) begin
        rx_value_reg <= rx_prod[31:0] + rx_off_reg;
      end
      if (rx_vld_reg) begin
        if ($signed(rx_value_reg) >= $signed(th_on_reg)) begin
          rx_on <= 1'b1;
        end else if ($signed(rx_value_reg) <= $signed(th_off_reg)) begin
          rx_on <= 1'b0;
        end
      end
    end
  end

  assign lost_set = ce && rx_en && !rx_hit && !rx_lost && ms_tick
                    && rx_cnt_reg + 16'h1 >= rx_tmo_reg;

  // Silence watchdog; a reception in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_cnt_reg <= 16'h0;
      rx_lost    <= 1'b0;
    end else if (ce) begin
      if (!rx_en || rx_hit) begin
        rx_cnt_reg <= 16'h0;
        rx_lost    <= 1'b0;
      end else if (lost_set) begin
        rx_lost <= 1'b1;
      end else if (ms_tick && !rx_lost) begin
        rx_cnt_reg <= rx_cnt_reg + 16'h1;
      end
    end
  end

  // =====================================================================
  // Interrupts: sticky, write one to clear, set beats clear
  always_comb begin
    irq_set              = '0;
    irq_set[cspu_pkg::I_TX]   = ce && tx_valid && tx_ready;
    irq_set[cspu_pkg::I_RX]   = rx_hit;
    irq_set[cspu_pkg::I_LOST] = lost_set;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else if (ce) begin
      if (wr_go && dp_addr_reg == cspu_pkg::A_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~hwdata[IW-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // =====================================================================
  // Checks
  sequence s_load;
    $rose(tx_valid);
  endsequence

  sequence s_stall;
    ce && !tx_ready;
  endsequence

  tx_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && tx_per_reg == 16'h0 && !tx_valid |=> !tx_valid)
    else $error("frame sent with zero period");
  tx_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_load ##0 s_stall |=> tx_valid && $stable(tx_data))
    else $error("frame dropped before taken");
  rx_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && rx_valid && rx_tmo_reg == 16'h0 |=> !rx_pend_reg)
    else $error("frame accepted while reception off");
  sa_filter_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && rx_valid && filt_en_reg && rx_id[7:0] != rx_sa_reg |=> !rx_pend_reg)
    else $error("foreign sender accepted");
  sa_default_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) |-> rx_sa_reg == cspu_pkg::SA_NULL && !filt_en_reg)
    else $error("sender address not null after reset");
  // Only a field that fits below bit 63 is compared; byte 4 and up may be cut
  tx_field_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_load ##0 (!$past(sig_cfg_reg[1][cspu_pkg::F_EN])
    && !$past(sig_cfg_reg[2][cspu_pkg::F_EN])
    && !$past(sig_cfg_reg[3][cspu_pkg::F_EN])
    && $past(sig_cfg_reg[0][cspu_pkg::F_EN])
    && !$past(sig_cfg_reg[0][cspu_pkg::F_BYTE + 2]))
    |-> extract(tx_data, $past(sig_cfg_reg[0]))
    == ($past(sig_raw[0]) & 32'(field_mask($past(sig_cfg_reg[0])))))
    else $error("transmit field misplaced");
  scale_def_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) |-> sig_scl_reg[0] == cspu_pkg::SCL_DEF && sig_off_reg[0] == 32'h0
    && sig_cfg_reg[0][cspu_pkg::F_SIZE +: 2] == 2'h1)
    else $error("scaling defaults wrong");
  rx_field_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rx_pend_reg |-> rx_raw_reg == extract($past(rx_data), $past(rx_cfg_reg)))
    else $error("received field misread");
  rx_onoff_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && rx_vld_reg && $signed(rx_value_reg) >= $signed(th_on_reg) |=> rx_on)
    else $error("on threshold ignored");
  lost_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rx_hit |=> !rx_lost ##1 1'b1)
    else $error("lost flag not cleared by reception");
  tx_ident_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_load |-> tx_id[28:26] == $past(prio_reg) && tx_id[7:0] == $past(sa_own_reg))
    else $error("identifier fields wrong");
endmodule

// file: src/cspu_pkg.sv
// =====================================================================
// Shared constants for the signal pack/unpack block
package cspu_pkg;
  // =====================================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_TX_PGN   = 8'h04;
  localparam logic [7:0] A_TX_PER   = 8'h08;
  localparam logic [7:0] A_TX_DEST  = 8'h0c;
  localparam logic [3:0] A_SIG_LO   = 4'h1;  // Signal n at 0x10 * (n + 1)
  localparam logic [3:0] A_SIG_HI   = 4'h4;
  localparam logic [1:0] A_SIG_CFG  = 2'h0;
  localparam logic [1:0] A_SIG_SCL  = 2'h1;
  localparam logic [1:0] A_SIG_OFF  = 2'h2;
  localparam logic [7:0] A_RX_PGN   = 8'h50;
  localparam logic [7:0] A_RX_TMO   = 8'h54;
  localparam logic [7:0] A_RX_SA    = 8'h58;
  localparam logic [7:0] A_RX_CFG   = 8'h5c;
  localparam logic [7:0] A_RX_RES   = 8'h60;
  localparam logic [7:0] A_RX_OFF   = 8'h64;
  localparam logic [7:0] A_RX_THOFF = 8'h68;
  localparam logic [7:0] A_RX_THON  = 8'h6c;
  localparam logic [7:0] A_RX_VAL   = 8'h70;
  localparam logic [7:0] A_STATUS   = 8'h74;
  localparam logic [7:0] A_IRQ_STAT = 8'h78;
  localparam logic [7:0] A_IRQ_MASK = 8'h7c;
  // =====================================================================
  // Field layouts
  localparam int CFG_W  = 13;
  localparam int F_SIZE = 0;   // 0 one byte, 1 two bytes, 2 or 3 four bytes
  localparam int F_BYTE = 4;
  localparam int F_BIT  = 8;
  localparam int F_EN   = 12;
  localparam int C_FILT = 8;   // Control: sender filter enable
  localparam int IRQ_W  = 3;
  localparam int I_TX   = 0;
  localparam int I_RX   = 1;
  localparam int I_LOST = 2;
  localparam logic [7:0] PF_PDU2 = 8'hf0;
  localparam int SCL_SH = 16;  // Transmit scale is Q16.16 bits per value LSB
  // =====================================================================
  // Reset values (values in milli-units, one LSB = 0.001)
  localparam logic [7:0]       SA_OWN_DEF = 8'h80;  // Arbitrary own address
  localparam logic [7:0]       SA_NULL    = 8'hfe;
  localparam logic [7:0]       DEST_DEF   = 8'hff;
  localparam logic [17:0]      TX_PGN_DEF = 18'h0ff00;
  localparam logic [17:0]      RX_PGN_DEF = 18'h0ff01;
  localparam logic [2:0]       PRIO_DEF   = 3'h6;
  localparam logic [CFG_W-1:0] CFG_SIG0   = 13'h1021;  // On, 2 bytes, byte 2
  localparam logic [CFG_W-1:0] CFG_SIGN   = 13'h0001;  // Off, 2 bytes, byte 0
  localparam logic [CFG_W-1:0] CFG_RX_DEF = 13'h0001;
  localparam logic [31:0]      SCL_DEF    = 32'h00010000;
  localparam logic [31:0]      RES_DEF    = 32'h00000001;
  localparam logic [31:0]      THON_DEF   = 32'h000007d0;
  // =====================================================================
  // Timing
  localparam int CLK_NS    = 25;
  localparam int MS_NS     = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
endpackage

// file: src/cspu_ms_tick.sv
`timescale 1ns/100ps
// =====================================================================
// Millisecond tick divider
module cspu_ms_tick #(
  parameter int CYCLES = 40000
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic ce,
  output logic      tick
);
  logic [31:0] cnt_reg;

  // Free running count, one pulse per wrap
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (ce) begin
      if (cnt_reg == 32'(CYCLES - 1)) begin
        cnt_reg <= 32'h0;
        tick    <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 32'h1;
        tick    <= 1'b0;
      end
    end
  end
endmodule

// file: src/cspu_tx_scale.sv
`timescale 1ns/100ps
// =====================================================================
// Transmit scaler: raw = ((value - offset) * scale) >> 16
module cspu_tx_scale (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [31:0] value,
  input  wire logic [31:0] offset,
  input  wire logic [31:0] scale,
  output logic      [31:0] raw
);
  logic signed [32:0] diff;
  logic signed [65:0] prod;

  // Wide product keeps sign; result is wrapped, not saturated
  assign diff = $signed({value[31], value}) - $signed({offset[31], offset});
  assign prod = 66'(diff * $signed({scale[31], scale}));

  // Registered so that the payload builder sees a stable word
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      raw <= 32'h0;
    end else if (ce) begin
      raw <= prod[cspu_pkg::SCL_SH +: 32];
    end
  end
endmodule

// file: dv/cspu_peer.sv
`timescale 1ns/100ps
// =====================================================================
// Far-side controller: takes frames, plays frames from other nodes
module cspu_peer (
  input  wire logic        sys_clk,
  input  wire logic        stall,
  input  wire logic        tx_valid,
  input  wire logic [28:0] tx_id,
  input  wire logic [63:0] tx_data,
  output logic             tx_ready,
  output logic             rx_valid,
  output logic      [28:0] rx_id,
  output logic      [63:0] rx_data,
  output int               frames,
  output logic      [28:0] last_id,
  output logic      [63:0] last_data
);
  // Stall holds the frame back, as a busy bus would
  assign tx_ready = !stall;
  initial begin
    rx_valid = 1'b0;
    rx_id = '0;
    rx_data = '0;
    frames = 0;
  end
  // Capture each frame at the edge it is handed over
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) begin
      frames <= frames + 1;
      last_id <= tx_id;
      last_data <= tx_data;
    end
  end
  // One-cycle frame; lines flip after so stale data never passes
  task send(input logic [28:0] id, input logic [63:0] d);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_data <= d;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_data <= ~d;
  endtask
endmodule

// file: dv/tb_top.sv
`timescale 1ns/100ps
// =====================================================================
// Bench for the signal pack/unpack block
module tb_top;
  logic sys_clk = 0, rst_b = 0, stall = 0, hsel = 0, hwrite = 0, ce = 1;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, s0 = 0, s1 = 0;
  logic hreadyout, hresp, tx_valid, tx_ready, rx_valid, rx_on, rx_lost, irq;
  logic [28:0] tx_id, rx_id, lid;
  logic [63:0] tx_data, rx_data, ldat, e;
  int frames, bad_count = 0, checks = 0, n;
  always #12.5 sys_clk = ~sys_clk;
  cspu_top #(.MS_CYCLES(10)) DUT (.sys_clk, .rst_b, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .sig_val_0(s0), .sig_val_1(s1), .sig_val_2(32'h0), .sig_val_3(32'h0), .tx_valid,
    .tx_ready, .tx_id, .tx_data, .rx_valid, .rx_id, .rx_data, .rx_on, .rx_lost, .irq);
  cspu_peer peer (.sys_clk, .stall, .tx_valid, .tx_ready, .tx_id, .tx_data, .rx_valid,
    .rx_id, .rx_data, .frames, .last_id(lid), .last_data(ldat));
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Single AHB word transfer; waits on hready, no assumed latency
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 0, 0);
    check(r, exp);
    check(hresp, 0);
  endtask
  // Wait for the next frame, bounded
  task next_frame;
    n = frames;
    for (int i = 0; i < 40 && frames == n; i++) @(posedge sys_clk);
    check(frames != n, 1);
  endtask
  task stop_test;
    $display("mismatches %0d checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // =====================================================================
  // Transmit: period, placement, scaling, identifier, interrupt
  task t_tx;
    repeat (60) @(posedge sys_clk);
    check(frames, 0);
    s0 <= 32'h1234; s1 <= 32'h7;
    bus(8'h08, 1, 32'h2);
    // First frames carry signal 0 alone, default two-byte field at byte 2
    next_frame;
    check(ldat, {32'hffffffff, 16'h1234, 16'hffff});
    // Clock enable low: the period count must stand still
    ce <= 0;
    n = frames;
    repeat (60) @(posedge sys_clk);
    check(frames, n);
    ce <= 1;
    bus(8'h20, 1, 32'h1350); bus(8'h24, 1, 32'h20000); bus(8'h28, 1, 32'h2);
    bus(8'h7c, 1, 32'h1);
    next_frame;
    e = '1; e[31:16] = 16'h1234; e[50:43] = 8'h0a;
    next_frame;
    check(ldat, e);
    check(lid, {3'h6, 18'h0ff00, 8'h80});
    repeat (2) @(posedge sys_clk);
    check(irq, 1);
    next_frame;
    stall <= 1; bus(8'h08, 1, 32'h0);
    repeat (30) @(posedge sys_clk);
    check(frames, n + 1);
    stall <= 0; bus(8'h78, 1, 32'h7); bus(8'h7c, 1, 32'h0);
    check(irq, 0);
  endtask
  // =====================================================================
  // Receive: enable, extract, thresholds, filter, lost link
  task t_rx;
    e = 0; e[23:8] = 16'h0bb8;
    peer.send({3'h6, 18'h0ff01, 8'h33}, e);
    repeat (5) @(posedge sys_clk);
    check(rx_on, 0);
    bus(8'h5c, 1, 32'h11); bus(8'h54, 1, 32'd20);
    peer.send({3'h6, 18'h0ff01, 8'h33}, e);
    repeat (5) @(posedge sys_clk);
    check({rx_on, rx_lost}, 2'b10);
    rdc(8'h70, 32'd3000);
    bus(8'h00, 1, 32'h180); bus(8'h58, 1, 32'h44);
    peer.send({3'h6, 18'h0ff01, 8'h33}, 0);
    repeat (5) @(posedge sys_clk);
    check(rx_on, 1);
    peer.send({3'h6, 18'h0ff01, 8'h44}, 0);
    repeat (5) @(posedge sys_clk);
    check(rx_on, 0);
    repeat (220) @(posedge sys_clk);
    rdc(8'h74, 32'h2);
    peer.send({3'h6, 18'h0ff01, 8'h44}, 0);
    repeat (3) @(posedge sys_clk);
    check(rx_lost, 0);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1;
    rdc(8'h58, 32'hfe);
    rdc(8'h00, 32'h80);
    rdc(8'h08, 32'h0);
    rdc(8'h30, 32'h1);
    rdc(8'hfc, 32'h0);
    t_tx;
    t_rx;
    stop_test;
  end
  // Whole run is about 600 cycles
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
endmodule
